// ==== shared/sfp_cfg.svh ====
// Constants for the serial flash status and protection front end.
// Assumes an 18-bit array address space and 8-bit command opcodes.
`ifndef SFP_CFG_SVH
`define SFP_CFG_SVH
// Command opcodes
`define SFP_OP_STATUS_WRITE_CMD   8'h01
`define SFP_OP_BPROG  8'h02
`define SFP_OP_WRITE_DISABLE_CMD   8'h04
`define SFP_OP_RDSR   8'h05
`define SFP_OP_WRITE_ENABLE_CMD   8'h06
`define SFP_OP_SE4K   8'h20
`define SFP_OP_RDSR1  8'h35
`define SFP_OP_BE32   8'h52
`define SFP_OP_CE_A   8'h60
`define SFP_OP_AAI    8'had
`define SFP_OP_CE_B   8'hc7
`define SFP_OP_BE64   8'hd8
// Status bit positions
`define SFP_SR_BUSY   0
`define SFP_SR_WEL    1
`define SFP_SR_BP_LO  2
`define SFP_SR_BP_HI  3
`define SFP_SR_AAI    6
`define SFP_SR_BPL    7
`define SFP_SR1_TOP   2
`define SFP_SR1_BOT   3
// Reset values
`define SFP_BP_RST    2'h3
`define SFP_SR_RST    8'h0c
// Frame lengths in bits
`define SFP_LEN_1B    6'h08
`define SFP_LEN_2B    6'h10
`define SFP_LEN_3B    6'h18
`define SFP_LEN_4B    6'h20
`define SFP_LEN_5B    6'h28
`define SFP_LEN_6B    6'h30
// Array map
`define SFP_TOP_ADDR  18'h3ffff
`define SFP_PROT_QTR  18'h30000
`define SFP_PROT_HALF 18'h20000
`define SFP_TOP_SECT  18'h3f000
`define SFP_BOT_END   18'h00fff
`define SFP_MASK_4K   18'h00fff
`define SFP_MASK_32K  18'h07fff
`define SFP_MASK_64K  18'h0ffff
`endif

// ==== shared/sfp_pkg.sv ====
// Types shared by the flash front end modules.
// Assumes sfp_cfg.svh for all numeric constants.
package sfp_pkg;
  typedef enum logic [1:0] {ph_idle = 2'b01, ph_busy = 2'b10} sfp_phase_t;

  typedef struct packed {
    sfp_phase_t  phase;
    logic        write_enable_latch;
    logic [1:0]  bp;
    logic        auto_increment_program;
    logic        protect_lockdown;
    logic        top_sector_lock;
    logic        bottom_sector_lock;
    logic        hold;
    logic        cs_prev;
    logic        so_oe;
    logic        req;
    logic [7:0]  op;
    logic [17:0] addr;
    logic [15:0] data;
    logic [7:0]  sr;
    logic [7:0]  sr1;
  } sfp_core_t;

  typedef struct packed {
    logic [47:0] word;
    logic [5:0]  cnt;
    logic        rd;
    logic        rd_alt;
  } sfp_shift_t;
endpackage : sfp_pkg

// ==== shared/sfp_link_if.sv ====
// Carrier between the serial-clock shifter and the core-clock logic.
// Assumes word and cnt are only read while chip select is high.
`timescale 1ns/1ps
interface sfp_link_if;
  logic [47:0] word;
  logic [5:0]  cnt;
  logic        rd_act;
  logic [7:0]  sr;
  logic [7:0]  sr1;

  modport shift (output word, output cnt, output rd_act,
                 input sr, input sr1);
  modport core (input word, input cnt, input rd_act,
                output sr, output sr1);
endinterface : sfp_link_if

// ==== rtl/sfp_sync.sv ====
// Two-flop level synchroniser with a chosen reset value.
// Assumes each bit is an independent level.
`timescale 1ns/1ps
module sfp_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  logic         clk,
  input  logic         rstn,
  input  logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sfp_sync_t;
  sfp_sync_t st_ff, nxt_st;

  // First stage feeds only the second stage
  always_comb begin
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) st_ff <= {RST, RST};
    else       st_ff <= nxt_st;
  end

  assign q = st_ff.s2;
endmodule : sfp_sync

// ==== rtl/sfp_shift.sv ====
// Serial-clock side: captures a frame, shifts status bytes out.
// Assumes the serial clock stops while chip select is high.
`timescale 1ns/1ps
`include "sfp_cfg.svh"
module sfp_shift (
  input  logic       sck,
  input  logic       rstn,
  input  logic       cs_n,
  input  logic       hold_n,
  input  logic       si,
  output logic       so_bit,
  sfp_link_if.shift  lnk
);
  import sfp_pkg::*;
  sfp_shift_t  st_ff, nxt_st;
  logic        armed_ff;
  logic        so_ff;
  logic [15:0] stat_s;
  logic [7:0]  first_op;
  logic [7:0]  sel;

  // Status images cross in on this clock
  sfp_sync #(.W(16), .RST(16'h0000)) u_stat (
    .clk (sck), .rstn (rstn), .d ({lnk.sr, lnk.sr1}), .q (stat_s));

  assign first_op = {st_ff.word[47:41], si};
  assign sel      = st_ff.rd_alt ? stat_s[7:0] : stat_s[15:8];

  // Rising edge sampling; a paused edge changes nothing
  always_comb begin
    nxt_st = st_ff;
    if (hold_n) begin
      if (armed_ff) begin
        nxt_st.word   = {si, 47'h0};
        nxt_st.cnt    = 6'h01;
        nxt_st.rd     = 1'b0;
        nxt_st.rd_alt = 1'b0;
      end else if (st_ff.rd) begin
        // Status read repeats the byte until deselect
        nxt_st.cnt = (st_ff.cnt == 6'h0f) ? `SFP_LEN_1B : st_ff.cnt + 6'h01;
      end else if (st_ff.cnt < `SFP_LEN_6B) begin
        nxt_st.word[6'h2f - st_ff.cnt] = si;
        nxt_st.cnt = st_ff.cnt + 6'h01;
        if (st_ff.cnt == 6'h07) begin
          nxt_st.rd     = (first_op == `SFP_OP_RDSR) ||
                          (first_op == `SFP_OP_RDSR1);
          nxt_st.rd_alt = (first_op == `SFP_OP_RDSR1);
        end
      end
    end
  end

  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) st_ff <= '0;
    else       st_ff <= nxt_st;
  end

  // Deselect rearms the frame; the captured word stays for the core
  always_ff @(posedge sck or posedge cs_n or negedge rstn) begin
    if (!rstn)       armed_ff <= 1'b1;
    else if (cs_n)   armed_ff <= 1'b1;
    else if (hold_n) armed_ff <= 1'b0;
  end

  // Output changes only after the falling edge
  always_ff @(negedge sck or negedge rstn) begin
    if (!rstn)                     so_ff <= 1'b0;
    else if (hold_n && st_ff.rd)   so_ff <= sel[~st_ff.cnt[2:0]];
  end

  assign so_bit     = so_ff;
  assign lnk.word   = st_ff.word;
  assign lnk.cnt    = st_ff.cnt;
  assign lnk.rd_act = st_ff.rd & ~armed_ff;

  a_shift_advance: assert property (
    @(posedge sck) disable iff (!rstn || cs_n)
    hold_n && !armed_ff && !st_ff.rd && st_ff.cnt < `SFP_LEN_6B
    |=> st_ff.cnt == $past(st_ff.cnt) + 6'h01)
    else $error("bit count did not advance on a sampled edge");

  a_hold_freeze: assert property (
    @(posedge sck) disable iff (!rstn || cs_n)
    !hold_n |=> st_ff == $past(st_ff))
    else $error("shifter moved while paused");
endmodule : sfp_shift

// ==== rtl/sfp_top.sv ====
// Serial flash front end: pause control, status registers, protection.
// Assumes the serial link runs on sck, the rest on core_clk, and a
// program/erase engine outside that answers requests with eng_done.
`timescale 1ns/1ps
`include "sfp_cfg.svh"
module sfp_top (
  input  logic        core_clk,
  input  logic        rstn,
  input  logic        sck,
  input  logic        cs_n,
  input  logic        si,
  input  logic        hold_n,
  input  logic        wp_n,
  input  logic        eng_done,
  input  logic        eng_aai_end,
  output logic        so_out,
  output logic        so_oe,
  output logic        eng_req,
  output logic [7:0]  eng_op,
  output logic [17:0] eng_addr,
  output logic [15:0] eng_data
);
  import sfp_pkg::*;

  localparam sfp_core_t CORE_RST = '{
    phase: ph_idle, write_enable_latch: 1'b0, bp: `SFP_BP_RST, auto_increment_program: 1'b0, protect_lockdown: 1'b0,
    top_sector_lock: 1'b0, bottom_sector_lock: 1'b0, hold: 1'b0, cs_prev: 1'b1, so_oe: 1'b0,
    req: 1'b0, op: 8'h00, addr: 18'h00000, data: 16'h0000,
    sr: `SFP_SR_RST, sr1: 8'h00};

  sfp_core_t   st_ff, nxt_st;
  sfp_link_if  lnk ();
  logic        cs_s, sck_s, hold_s, wp_s, rd_s;
  logic        cs_rise, frame_ok, status_write_cmd_allowed, blocked, is_aai_cont;
  logic [7:0]  f_op, f_b1, f_b2;
  logic [17:0] f_addr, t_addr;
  logic [5:0]  f_len;

  // Program and erase opcodes
  function automatic logic is_wr_op(input logic [7:0] op);
    return op == `SFP_OP_BPROG || op == `SFP_OP_AAI ||
           op == `SFP_OP_SE4K  || op == `SFP_OP_BE32 ||
           op == `SFP_OP_BE64  || is_chip(op);
  endfunction : is_wr_op

  function automatic logic is_chip(input logic [7:0] op);
    return op == `SFP_OP_CE_A || op == `SFP_OP_CE_B;
  endfunction : is_chip

  // Frame length that a write command must have
  function automatic logic [5:0] wr_len(input logic [7:0] op,
                                        input logic       auto_increment_program);
    case (op)
      `SFP_OP_BPROG: wr_len = `SFP_LEN_5B;
      `SFP_OP_AAI:   wr_len = auto_increment_program ? `SFP_LEN_3B : `SFP_LEN_6B;
      `SFP_OP_CE_A,
      `SFP_OP_CE_B:  wr_len = `SFP_LEN_1B;
      default:       wr_len = `SFP_LEN_4B;
    endcase
  endfunction : wr_len

  // Target range against protected area and locked sectors
  function automatic logic prot_hit(input logic [7:0]  op,
                                    input logic [17:0] addr,
                                    input logic [1:0]  bp,
                                    input logic        top_sector_lock,
                                    input logic        bottom_sector_lock);
    logic [17:0] lo;
    logic [17:0] hi;
    logic [17:0] pstart;
    lo = addr;
    hi = addr;
    case (op)
      `SFP_OP_SE4K: begin
        lo = addr & ~`SFP_MASK_4K;
        hi = addr | `SFP_MASK_4K;
      end
      `SFP_OP_BE32: begin
        lo = addr & ~`SFP_MASK_32K;
        hi = addr | `SFP_MASK_32K;
      end
      `SFP_OP_BE64: begin
        lo = addr & ~`SFP_MASK_64K;
        hi = addr | `SFP_MASK_64K;
      end
      `SFP_OP_CE_A, `SFP_OP_CE_B: begin
        lo = 18'h00000;
        hi = `SFP_TOP_ADDR;
      end
      `SFP_OP_AAI: hi = addr | 18'h00001;
      default:     hi = addr;
    endcase
    case (bp)
      2'h1:    pstart = `SFP_PROT_QTR;
      2'h2:    pstart = `SFP_PROT_HALF;
      default: pstart = 18'h00000;
    endcase
    prot_hit = ((bp != 2'h0) && (hi >= pstart)) ||
               (top_sector_lock && (hi >= `SFP_TOP_SECT)) ||
               (bottom_sector_lock && (lo <= `SFP_BOT_END));
  endfunction : prot_hit

  // Pins and the read flag cross into the core clock
  sfp_sync #(.W(5), .RST(5'h16)) u_pins (
    .clk  (core_clk),
    .rstn (rstn),
    .d    ({cs_n, sck, hold_n, wp_n, lnk.rd_act}),
    .q    ({cs_s, sck_s, hold_s, wp_s, rd_s}));

  // Serial clock side of the link
  sfp_shift u_shift (
    .sck    (sck),
    .rstn   (rstn),
    .cs_n   (cs_n),
    .hold_n (hold_n),
    .si     (si),
    .so_bit (so_out),
    .lnk    (lnk.shift));

  // Captured word is stable once the frame has ended
  assign f_op   = lnk.word[47:40];
  assign f_b1   = lnk.word[39:32];
  assign f_b2   = lnk.word[31:24];
  assign f_addr = lnk.word[33:16];
  assign f_len  = lnk.cnt;

  // Frame end seen after sync; aborted frames and busy time skipped
  assign cs_rise      = cs_s & ~st_ff.cs_prev;
  assign frame_ok     = cs_rise & ~st_ff.hold &
                        (st_ff.phase == ph_idle);
  assign status_write_cmd_allowed = wp_s | ~st_ff.protect_lockdown;
  assign is_aai_cont  = (f_op == `SFP_OP_AAI) & st_ff.auto_increment_program;
  // Continuation carries no address; check the word it will really hit
  assign t_addr       = is_aai_cont ? st_ff.addr + 18'h00002 : f_addr;
  assign blocked      = prot_hit(f_op, t_addr, st_ff.bp, st_ff.top_sector_lock,
                                 st_ff.bottom_sector_lock) ||
                        (is_chip(f_op) && st_ff.bp != 2'h0);

  // Next state of the core
  always_comb begin
    nxt_st         = st_ff;
    nxt_st.req     = 1'b0;
    nxt_st.cs_prev = cs_s;
    // Pause follows hold only while the clock is low
    if (!sck_s) begin
      nxt_st.hold = ~hold_s & (~cs_s | st_ff.hold);
    end
    // Engine completion
    if (eng_done) begin
      nxt_st.phase = ph_idle;
      if (!st_ff.auto_increment_program) nxt_st.write_enable_latch = 1'b0;
    end
    if (eng_aai_end) begin
      nxt_st.auto_increment_program = 1'b0;
      nxt_st.write_enable_latch = 1'b0;
    end
    if (frame_ok) begin
      case (f_op)
        `SFP_OP_WRITE_ENABLE_CMD: begin
          if (f_len == `SFP_LEN_1B) nxt_st.write_enable_latch = 1'b1;
        end
        `SFP_OP_WRITE_DISABLE_CMD: begin
          if (f_len == `SFP_LEN_1B) begin
            nxt_st.write_enable_latch = 1'b0;
            nxt_st.auto_increment_program = 1'b0;
          end
        end
        `SFP_OP_STATUS_WRITE_CMD: begin
          if ((f_len == `SFP_LEN_2B || f_len == `SFP_LEN_3B) &&
              st_ff.write_enable_latch) begin
            nxt_st.write_enable_latch = 1'b0;
            if (status_write_cmd_allowed) begin
              nxt_st.bp  = f_b1[`SFP_SR_BP_HI:`SFP_SR_BP_LO];
              nxt_st.protect_lockdown = f_b1[`SFP_SR_BPL];
              if (f_len == `SFP_LEN_3B) begin
                nxt_st.top_sector_lock = f_b2[`SFP_SR1_TOP];
                nxt_st.bottom_sector_lock = f_b2[`SFP_SR1_BOT];
              end
            end
          end
        end
        default: begin
          if (is_wr_op(f_op) && st_ff.write_enable_latch && !blocked &&
              f_len == wr_len(f_op, st_ff.auto_increment_program)) begin
            nxt_st.req   = 1'b1;
            nxt_st.phase = ph_busy;
            nxt_st.op    = f_op;
            if (is_aai_cont) begin
              nxt_st.addr = st_ff.addr + 18'h00002;
              nxt_st.data = lnk.word[39:24];
            end else begin
              nxt_st.addr = f_addr;
              nxt_st.data = lnk.word[15:0];
            end
            if (f_op == `SFP_OP_AAI) nxt_st.auto_increment_program = 1'b1;
          end
        end
      endcase
    end
    // Status images; reserved bits stay zero
    nxt_st.sr = {nxt_st.protect_lockdown, nxt_st.auto_increment_program, 2'b00, nxt_st.bp, nxt_st.write_enable_latch,
                 nxt_st.phase == ph_busy};
    nxt_st.sr1 = {4'h0, nxt_st.bottom_sector_lock, nxt_st.top_sector_lock, 2'b00};
    // Output released whenever paused or deselected
    nxt_st.so_oe = ~cs_s & ~nxt_st.hold & rd_s;
  end

  // Every register runs on every edge
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) st_ff <= CORE_RST;
    else       st_ff <= nxt_st;
  end

  // Status bytes handed to the shifter; sr is a per-bit level
  assign lnk.sr   = st_ff.sr;
  assign lnk.sr1  = st_ff.sr1;
  assign so_oe    = st_ff.so_oe;
  assign eng_req  = st_ff.req;
  assign eng_op   = st_ff.op;
  assign eng_addr = st_ff.addr;
  assign eng_data = st_ff.data;

  default clocking dflt_cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  a_status_write_cmd_refused: assert property (
    frame_ok && f_op == `SFP_OP_STATUS_WRITE_CMD && !wp_s && st_ff.protect_lockdown
    |=> st_ff.bp == $past(st_ff.bp) && st_ff.protect_lockdown)
    else $error("status write took effect while locked down");

  a_busy_bit: assert property (
    st_ff.req |-> st_ff.sr[`SFP_SR_BUSY] ##1
    (st_ff.sr[`SFP_SR_BUSY] || $past(eng_done)))
    else $error("busy bit missing after an accepted request");

  a_wel_mirror: assert property (
    st_ff.sr[`SFP_SR_WEL] == st_ff.write_enable_latch &&
    st_ff.sr[`SFP_SR_AAI] == st_ff.auto_increment_program)
    else $error("status image out of step with latch state");

  a_req_needs_wel: assert property (
    st_ff.req |-> $past(st_ff.write_enable_latch) && $past(frame_ok))
    else $error("request issued with write enable clear");

  a_wel_clear_done: assert property (
    eng_done && !st_ff.auto_increment_program && !frame_ok |=> !st_ff.write_enable_latch)
    else $error("write enable survived a completion");

  a_chip_erase_bp: assert property (
    st_ff.req && is_chip(st_ff.op) |-> $past(st_ff.bp) == 2'h0)
    else $error("chip erase issued under block protection");

  a_top_lock: assert property (
    st_ff.req && $past(st_ff.top_sector_lock) |-> st_ff.addr < `SFP_TOP_SECT)
    else $error("request reached a locked top sector");

  a_hold_entry: assert property (
    !sck_s && !hold_s && !cs_s |=> st_ff.hold && !st_ff.so_oe)
    else $error("pause not entered with clock low");

  a_hold_exit: assert property (
    st_ff.hold && !sck_s && hold_s |=> !st_ff.hold)
    else $error("pause not left with clock low");

  a_hold_release: assert property (
    st_ff.hold |-> !st_ff.so_oe)
    else $error("output driven while paused");

  a_abandon_frame: assert property (
    cs_rise && st_ff.hold |=> !st_ff.req && st_ff.write_enable_latch == $past(st_ff.write_enable_latch))
    else $error("frame ended in pause was executed");

  a_reserved_zero: assert property (
    st_ff.sr[5:4] == 2'b00 && st_ff.sr1[7:4] == 4'h0 &&
    st_ff.sr1[1:0] == 2'b00)
    else $error("reserved status bit set");

  a_req_pulse: assert property (
    st_ff.req |=> !st_ff.req [*2])
    else $error("request repeated while busy");
endmodule : sfp_top

// ==== verif/sfp_host_model.sv ====
// SPI host model for the flash front end, clock mode 0 or 3.
// Assumes the bench calls xfer; sck runs only inside frames.
`timescale 1ns/1ps
module sfp_host_model (
  input  logic mode3,
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n,
  input  logic so_out,
  input  logic so_oe
);
  // Deselected, not paused
  initial begin
    cs_n   = 1'b1;
    sck    = 1'b0;
    si     = 1'b0;
    hold_n = 1'b1;
  end

  // One frame, MSB first, 64 ns bit time; optional pause before bit hp.
  // Abort raises select while paused. rd keeps the last 8 bits seen.
  task automatic xfer(input logic [47:0] w, input int n, input int hp,
                      input bit ab, output logic [7:0] rd,
                      output logic poe);
    rd  = 8'h00;
    poe = 1'b0;
    sck = mode3;
    #32 cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (i == hp) begin
        // Pause falls with sck high, so entry waits for sck low
        hold_n = 1'b0;
        #16 sck = 1'b0;
        #32;
        repeat (2) begin
          si = ~si;
          sck = 1'b1;
          #32 sck = 1'b0;
          #32;
        end
        sck = 1'b1;
        #16 poe = so_oe;
        if (ab) begin
          sck = mode3;
          #16 cs_n = 1'b1;
          #64 hold_n = 1'b1;
          #64;
          return;
        end
        hold_n = 1'b1;
        #16;
      end
      sck = 1'b0;
      si = w[47-i];
      #32 sck = 1'b1;
      rd = {rd[6:0], (so_oe === 1'b1) ? so_out : 1'bx};
      #32;
    end
    sck = mode3;
    #32 cs_n = 1'b1;
    si = ~si; // Released line shows no stale value
    #64;
  endtask : xfer
endmodule : sfp_host_model

// ==== verif/test_spi_flash_status_protect.sv ====
// Self-checking bench for the flash status and protection front end.
// Assumes sfp_host_model as SPI host; the bench stands in for the engine.
`timescale 1ns/1ps
module test_spi_flash_status_protect;
  logic        core_clk;
  logic        rstn;
  logic        wp_n;
  logic        eng_done;
  logic        mode3;
  logic        sck;
  logic        cs_n;
  logic        si;
  logic        hold_n;
  logic        so_out;
  logic        so_oe;
  logic        eng_req;
  logic [7:0]  eng_op;
  logic [17:0] eng_addr;
  logic [15:0] eng_data;
  logic        eng_aai_end;
  logic [7:0]  sr_x;
  logic [7:0]  v;
  logic        p;
  int          n_errors = 0;
  int          checks = 0;
  int          n_req = 0;
  int          n0;
  int          cyc = 0;
  logic [7:0]  ops [4] = '{8'h02, 8'h52, 8'h20, 8'hd8};
  logic [17:0] adr [4] = '{18'h10000, 18'h20000, 18'h30000, 18'h3f000};

  sfp_top dut_u (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .sck         (sck),
    .cs_n        (cs_n),
    .si          (si),
    .hold_n      (hold_n),
    .wp_n        (wp_n),
    .eng_done    (eng_done),
    .eng_aai_end (eng_aai_end),
    .so_out      (so_out),
    .so_oe       (so_oe),
    .eng_req     (eng_req),
    .eng_op      (eng_op),
    .eng_addr    (eng_addr),
    .eng_data    (eng_data)
  );

  sfp_host_model host_u (
    .mode3  (mode3),
    .cs_n   (cs_n),
    .sck    (sck),
    .si     (si),
    .hold_n (hold_n),
    .so_out (so_out),
    .so_oe  (so_oe)
  );

  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;

  // Engine stand-in: done 300 cycles after each request
  always begin
    @(posedge core_clk);
    if (eng_req === 1'b1) begin
      n_req++;
      repeat (300) @(posedge core_clk);
      #1 eng_done = 1'b1;
      @(posedge core_clk);
      #1 eng_done = 1'b0;
    end
  end

  // Hang guard, well above the expected run length
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic frm(input logic [47:0] w, input int n);
    logic [7:0] r;
    logic       q;
    host_u.xfer(w, n, -1, 1'b0, r, q);
  endtask : frm

  task automatic op8(input logic [7:0] op);
    frm({op, 40'h0}, 8);
  endtask : op8

  task automatic sr_is(input logic [7:0] op, input logic [7:0] e);
    logic [7:0] r;
    logic       q;
    host_u.xfer({op, 40'h0}, 16, -1, 1'b0, r, q);
    chk("status read", r, e);
  endtask : sr_is

  // Status write of one byte (n 16) or two (n 24), enabled first
  task automatic status_write_cmd(input logic [7:0] a, b, input int n);
    op8(8'h06);
    frm({8'h01, a, b, 24'h0}, n);
  endtask : status_write_cmd

  // Enabled program or erase; accepted ones are polled while busy
  task automatic try_op(input logic [7:0] op, input logic [17:0] a,
                        input bit ok);
    n0 = n_req;
    op8(8'h06);
    if (op == 8'h60 || op == 8'hc7) frm({op, 40'h0}, 8);
    else if (op == 8'h02) frm({op, 6'h0, a, 8'h5a, 8'h0}, 40);
    else frm({op, 6'h0, a, 16'h0}, 32);
    repeat (10) @(posedge core_clk);
    chk("request", 8'(n_req - n0), {7'h0, ok});
    if (ok) begin
      chk("opcode", eng_op, op);
      chk("address", eng_addr[17:10], a[17:10]);
      sr_is(8'h05, sr_x | 8'h03);
      repeat (400) @(posedge core_clk);
    end
    else op8(8'h04);
    sr_is(8'h05, sr_x);
  endtask : try_op

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  // Main sequence
  initial begin
    core_clk = 1'b0;
    rstn = 1'b0;
    wp_n = 1'b1;
    eng_done = 1'b0;
    eng_aai_end = 1'b0;
    mode3 = 1'b0;
    repeat (20) @(posedge core_clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge core_clk);
    sr_is(8'h05, 8'h0c);
    sr_is(8'h35, 8'h00);
    $display("test power-up done");
    op8(8'h06);
    sr_is(8'h05, 8'h0e);
    mode3 = 1'b1;
    op8(8'h04);
    sr_is(8'h05, 8'h0c);
    n0 = n_req;
    frm({8'h02, 6'h0, 18'h00100, 8'h5a, 8'h0}, 40);
    repeat (10) @(posedge core_clk);
    chk("unlatched request", 8'(n_req - n0), 8'h00);
    sr_x = 8'h0c;
    try_op(8'hc7, 18'h0, 1'b0);
    status_write_cmd(8'h33, 8'hf7, 24);
    sr_x = 8'h00;
    sr_is(8'h05, 8'h00);
    sr_is(8'h35, 8'h04);
    mode3 = 1'b0;
    $display("test latch and status write done");
    // Each level against four targets; top sector locked throughout
    for (int l = 0; l < 4; l++) begin
      status_write_cmd(8'(l << 2), 8'h00, 16);
      sr_x = 8'(l << 2);
      for (int k = 0; k < 4; k++) try_op(ops[k], adr[k], k < 3 - l);
    end
    sr_is(8'h35, 8'h04);
    status_write_cmd(8'h00, 8'h08, 24);
    sr_x = 8'h00;
    sr_is(8'h35, 8'h08);
    try_op(8'h02, 18'h00010, 1'b0);
    try_op(8'h02, 18'h3f000, 1'b1);
    try_op(8'h60, 18'h0, 1'b0);
    status_write_cmd(8'h00, 8'h00, 24);
    try_op(8'h60, 18'h0, 1'b1);
    try_op(8'hc7, 18'h0, 1'b1);
    $display("test protection done");
    @(posedge core_clk);
    #1 wp_n = 1'b0;
    status_write_cmd(8'h80, 8'h00, 24);
    sr_is(8'h05, 8'h80);
    status_write_cmd(8'h8c, 8'h0c, 24);
    sr_is(8'h05, 8'h80);
    sr_is(8'h35, 8'h00);
    @(posedge core_clk);
    #1 wp_n = 1'b1;
    status_write_cmd(8'h00, 8'h00, 24);
    sr_is(8'h05, 8'h00);
    $display("test lockdown done");
    host_u.xfer({8'h06, 40'h0}, 8, 3, 1'b0, v, p);
    sr_is(8'h05, 8'h02);
    host_u.xfer({8'h05, 40'h0}, 16, 12, 1'b0, v, p);
    chk("paused output enable", {7'h0, p}, 8'h00);
    chk("paused read", v, 8'h02);
    op8(8'h04);
    host_u.xfer({8'h06, 40'h0}, 8, 4, 1'b1, v, p);
    sr_is(8'h05, 8'h00);
    $display("test pause done");
    mode3 = 1'b1;
    op8(8'h06);
    frm({8'had, 6'h0, 18'h00100, 8'ha5, 8'h5a}, 48);
    repeat (400) @(posedge core_clk);
    chk("auto-increment data", eng_data[7:0], 8'h5a);
    host_u.xfer({8'h05, 40'h0}, 16, -1, 1'b0, v, p);
    chk("auto-increment flag", v & 8'h40, 8'h40);
    frm({8'had, 8'h11, 8'h22, 24'h0}, 24);
    repeat (400) @(posedge core_clk);
    chk("continued address", eng_addr[7:0], 8'h02);
    chk("continued data", eng_data[15:8], 8'h11);
    op8(8'h04);
    sr_is(8'h05, 8'h00);
    op8(8'h06);
    frm({8'had, 6'h0, 18'h00100, 8'ha5, 8'h5a}, 48);
    repeat (400) @(posedge core_clk);
    #1 eng_aai_end = 1'b1;
    @(posedge core_clk);
    #1 eng_aai_end = 1'b0;
    sr_is(8'h05, 8'h00);
    $display("test auto-increment done");
    final_report();
  end
endmodule : test_spi_flash_status_protect
